// ### spi_shift_defines.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 32-bit apb data, one aligned word per register
// Notes:   definitions only
`ifndef SPI_SHIFT_DEFINES_SVH
`define SPI_SHIFT_DEFINES_SVH
// register byte offsets
`define OFS_CONTROL      8'h00
`define OFS_FORMAT       8'h04
`define OFS_DATA         8'h08
// control register fields
`define CTL_ENABLE       0
`define CTL_MASTER       1
// serial_format_control fields
`define FMT_TRF          0
`define FMT_WRITE_COLLISION_FLAG         1
`define FMT_SELECT_PIN_ENABLE         2
`define FMT_LSB          3
`define FMT_CAPTURE_EDGE_SELECT         4
`define FMT_POL          5
// reset values
`define RST_BYTE         8'h00
`define RST_WORD         32'h0000_0000
// master clock half period in system clocks
`define HALF_DIV_DEF     4
// clock edges in one byte transfer
`define EDGES_PER_BYTE   5'h10
`endif

// ### spi_shift_pkg.sv
// Purpose: shared types of the serial shift engine
// Assumes: nothing
// Notes:   constants live in spi_shift_defines.svh
package spi_shift_pkg;
  // master sequencer state
  typedef enum logic [0:0] {
    M_IDLE = 1'b0,
    M_RUN  = 1'b1
  } mstate_e;
endpackage

// ### spi_link_if.sv
// Purpose: carrier between system domain and link-clock domain
// Assumes: tx_word and config bits are quasi static during a frame
// Notes:   done_tgl is a toggle event, rx_word stable between events
`timescale 1ns/1ps
`default_nettype none
interface spi_link_if;
  logic       link_rst;   // system-side reset for link flops
  logic       sel_n;      // frame reset, high while not selected
  logic       cap_rising; // capture on rising sck
  logic       lsb_first;  // bit order
  logic [7:0] tx_word;    // byte to shift out
  logic [7:0] rx_word;    // byte shifted in
  logic       done_tgl;   // toggles per finished byte
  logic       sdo_bit;    // slave outgoing bit
  modport sys  (output link_rst, sel_n, cap_rising, lsb_first, tx_word,
                input rx_word, done_tgl, sdo_bit);
  modport link (input link_rst, sel_n, cap_rising, lsb_first, tx_word,
                output rx_word, done_tgl, sdo_bit);
endinterface
`default_nettype wire

// ### spi_link_slave.sv
// Purpose: slave shifter clocked by the external master's sck
// Assumes: clock stands still outside frames
// Notes:   counter cleared asynchronously while deselected
`timescale 1ns/1ps
`default_nettype none
module spi_link_slave (
  input wire logic sck,
  input wire logic sdi,
  spi_link_if.link lk
);
  logic       cap_clk;    // capture edge always rising here
  logic [2:0] cnt;        // bits captured in this byte
  logic [7:0] rx_sh;      // incoming shift register
  logic [2:0] next_cnt;
  logic [7:0] next_rx_sh;
  logic [7:0] rx_word;
  logic [7:0] next_rx_word;
  logic       done_tgl;
  logic       next_done_tgl;
  logic       frame_rst;

  // polarity and edge pick the capture edge
  assign cap_clk   = sck ^ ~lk.cap_rising;
  assign frame_rst = lk.sel_n | lk.link_rst;

  // first bit stands from selection on, next after each capture
  assign lk.sdo_bit  = lk.tx_word[lk.lsb_first ? cnt : 3'h7 - cnt];
  assign lk.rx_word  = rx_word;
  assign lk.done_tgl = done_tgl;

  // next shift state
  always_comb begin
    next_cnt      = cnt + 3'h1;
    next_rx_sh    = lk.lsb_first ? {sdi, rx_sh[7:1]} : {rx_sh[6:0], sdi};
    next_rx_word  = rx_word;
    next_done_tgl = done_tgl;
    if (cnt == 3'h7) begin // byte complete
      next_rx_word  = next_rx_sh;
      next_done_tgl = ~done_tgl;
    end
  end

  // frame flops, cleared while deselected
  always_ff @(posedge cap_clk or posedge frame_rst) begin
    if (frame_rst) begin
      cnt   <= 3'h0;
      rx_sh <= 8'h00;
    end else begin
      cnt   <= next_cnt;
      rx_sh <= next_rx_sh;
    end
  end

  // result flops, survive deselection
  always_ff @(posedge cap_clk or posedge lk.link_rst) begin
    if (lk.link_rst) begin
      rx_word  <= 8'h00;
      done_tgl <= 1'b0;
    end else begin
      rx_word  <= next_rx_word;
      done_tgl <= next_done_tgl;
    end
  end

  // a byte ends every eighth capture
  cnt_wrap_a: assert property (@(posedge cap_clk) disable iff (frame_rst)
    (cnt == 3'h7) |=> (done_tgl != $past(done_tgl)))
    else $error("slave byte end did not toggle done");
endmodule // spi_link_slave
`default_nettype wire

// ### spi_shift_engine.sv
// Purpose: spi master/slave shift engine behind an apb slave
// Assumes: LINK_SCK is the external sck pin, own clock domain
// Notes:   one wait state on every apb access
//
// Function
// - no traffic until interface enable set
// - master data write starts full-duplex transfer
// - transfer end sets sticky complete flag
// - slave shifts data on master clocks
// - slave first bit ready at selection
// - keeps working in idle power mode
// - select enable clear means always selected
//
// The address map and the APB interface to the registers are this design's own decisions.
`include "spi_shift_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module spi_shift_engine import spi_shift_pkg::*; #(
  parameter int HALF_DIV = `HALF_DIV_DEF
) (
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        LINK_SCK,
  input  wire logic        SDI,
  input  wire logic        SCS_N_IN,
  output logic             SCK_OUT,
  output logic             SCK_OE,
  output logic             SDO_OUT,
  output logic             SDO_OE,
  output logic             SCS_N_OUT,
  output logic             SCS_N_OE
);
  spi_link_if lk ();

  // register state
  logic       enable, master;           // control
  logic [1:0] spare;                    // free bits 7..6
  logic       pol, capture_edge_select, lsb, select_pin_enable;     // format
  logic       write_collision_flag, transfer_complete_flag;                // flags
  logic [7:0] data;                     // shift_data_register
  logic       next_enable, next_master;
  logic [1:0] next_spare;
  logic       next_pol, next_capture_edge_select, next_lsb, next_select_pin_enable;
  logic       next_write_collision_flag, next_trf;
  logic [7:0] next_data;
  // apb answer
  logic [31:0] next_prdata;
  logic        next_pready, next_pslverr;
  // master sequencer
  mstate_e    mst, next_mst;
  logic [15:0] div, next_div;            // half period counter
  logic [4:0] edges, next_edges;        // sck edges done
  logic [7:0] tx_sh, next_tx_sh;
  logic [7:0] rx_sh, next_rx_sh;
  logic       sck, next_sck;
  logic       msdo, next_msdo;
  // synchronisers and crossing
  logic       sdi_s1, sdi_s2;
  logic       scs_s1, scs_s2;
  logic       dn_s1, dn_s2, dn_s3;
  logic       link_rst;
  // decoded strobes
  logic       acc, wr, rd, hit;
  logic       wr_data, wr_fmt, wr_ctl;
  logic       slv_busy, busy;
  logic       m_done, s_done, tick, cap_edge;
  logic       pads_oe;
  logic       lsb_first;                // order bit clear means lsb first

  // apb access phase: writes when ready, reads while answer pending
  assign acc     = PSEL & PENABLE & PREADY;
  assign wr      = acc & PWRITE;
  assign rd      = PSEL & PENABLE & ~PREADY & ~PWRITE;
  assign hit     = (PADDR == `OFS_CONTROL) | (PADDR == `OFS_FORMAT) | (PADDR == `OFS_DATA);
  assign wr_ctl  = wr & (PADDR == `OFS_CONTROL);
  assign wr_fmt  = wr & (PADDR == `OFS_FORMAT);
  assign wr_data = wr & (PADDR == `OFS_DATA);

  // slave busy only observable when the select pin is in use
  assign slv_busy = enable & ~master & select_pin_enable & ~scs_s2;
  assign busy     = (mst == M_RUN) | slv_busy;
  assign s_done   = dn_s2 ^ dn_s3;       // byte landed from link side
  assign m_done   = (mst == M_RUN) & tick & (edges == `EDGES_PER_BYTE - 5'h1);
  assign tick     = (div == 16'(HALF_DIV - 1));
  // capture on leading edge (even count) when capture_edge_select set
  assign cap_edge = (edges[0] == 1'b0) == capture_edge_select;

  // link side configuration, frame reset from select or enable
  assign lk.link_rst   = link_rst;
  assign lk.sel_n      = ~enable | master | (select_pin_enable & SCS_N_IN);
  assign lk.cap_rising = pol ~^ capture_edge_select;
  assign lsb_first     = ~lsb;
  assign lk.lsb_first  = lsb_first;
  assign lk.tx_word    = data;

  spi_link_slave u_slave (
    .sck (LINK_SCK),
    .sdi (SDI),
    .lk  (lk)
  );

  // register next values
  always_comb begin
    next_enable = enable;
    next_master = master;
    next_spare  = spare;
    next_pol    = pol;
    next_capture_edge_select   = capture_edge_select;
    next_lsb    = lsb;
    next_select_pin_enable   = select_pin_enable;
    next_write_collision_flag   = write_collision_flag;
    next_trf    = transfer_complete_flag;
    next_data   = data;
    if (wr_ctl) begin
      next_enable = PWDATA[`CTL_ENABLE];
      next_master = PWDATA[`CTL_MASTER];
    end
    if (wr_fmt) begin
      next_spare = PWDATA[7:6];
      next_pol   = PWDATA[`FMT_POL];
      next_capture_edge_select  = PWDATA[`FMT_CAPTURE_EDGE_SELECT];
      next_lsb   = PWDATA[`FMT_LSB];
      next_select_pin_enable  = PWDATA[`FMT_SELECT_PIN_ENABLE];
      // flags clear on written zero only
      next_write_collision_flag  = write_collision_flag & PWDATA[`FMT_WRITE_COLLISION_FLAG];
      next_trf   = transfer_complete_flag & PWDATA[`FMT_TRF];
    end
    if (wr_data) begin
      if (busy) begin
        next_write_collision_flag = 1'b1;
      end else begin
        next_data = PWDATA[7:0];
      end
    end
    // hardware set wins over software clear
    if (m_done | s_done) begin
      next_trf = 1'b1;
    end
    if (m_done) begin
      next_data = next_rx_sh;
    end else if (s_done) begin
      next_data = lk.rx_word;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      enable <= 1'b0;
      master <= 1'b0;
      spare  <= 2'b00;
      pol    <= 1'b0;
      capture_edge_select   <= 1'b0;
      lsb    <= 1'b0;
      select_pin_enable   <= 1'b0;
      write_collision_flag   <= 1'b0;
      transfer_complete_flag    <= 1'b0;
      data   <= `RST_BYTE;
    end else begin
      enable <= next_enable;
      master <= next_master;
      spare  <= next_spare;
      pol    <= next_pol;
      capture_edge_select   <= next_capture_edge_select;
      lsb    <= next_lsb;
      select_pin_enable   <= next_select_pin_enable;
      write_collision_flag   <= next_write_collision_flag;
      transfer_complete_flag    <= next_trf;
      data   <= next_data;
    end
  end

  // apb answer, ready one cycle into the access phase
  always_comb begin
    next_pready  = PSEL & PENABLE & ~PREADY;
    next_pslverr = PSEL & PENABLE & ~PREADY & ~hit;
    next_prdata  = `RST_WORD;
    if (rd) begin
      unique case (PADDR)
        `OFS_CONTROL: next_prdata = {30'h0, master, enable};
        `OFS_FORMAT:  next_prdata = {24'h0, spare, pol, capture_edge_select, lsb, select_pin_enable, write_collision_flag, transfer_complete_flag};
        `OFS_DATA:    next_prdata = {24'h0, data};
        default:      next_prdata = `RST_WORD;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= `RST_WORD;
    end else begin
      PREADY  <= next_pready;
      PSLVERR <= next_pslverr;
      PRDATA  <= next_prdata;
    end
  end

  // master sequencer; runs regardless of cpu power state
  always_comb begin
    next_mst   = mst;
    next_div   = div;
    next_edges = edges;
    next_tx_sh = tx_sh;
    next_rx_sh = rx_sh;
    next_sck   = sck;
    next_msdo  = msdo;
    unique case (mst)
      M_IDLE: begin
        next_sck = ~pol;
        next_msdo = lsb_first ? tx_sh[0] : tx_sh[7];
        if (wr_data & enable & master) begin
          next_mst   = M_RUN;
          next_tx_sh = PWDATA[7:0];
          next_msdo  = lsb_first ? PWDATA[0] : PWDATA[7];
          next_div   = 16'h0;
          next_edges = 5'h0;
        end
      end
      M_RUN: begin
        next_div = tick ? 16'h0 : div + 16'h1;
        if (tick) begin
          next_sck   = ~sck;
          next_edges = edges + 5'h1;
          if (cap_edge) begin
            // sample then present following bit
            next_rx_sh = lsb_first ? {sdi_s2, rx_sh[7:1]} : {rx_sh[6:0], sdi_s2};
            next_tx_sh = lsb_first ? {1'b0, tx_sh[7:1]} : {tx_sh[6:0], 1'b0};
            next_msdo  = lsb_first ? tx_sh[1] : tx_sh[6];
          end
          if (m_done) begin
            next_mst = M_IDLE;
          end
        end
        if (~enable) begin
          next_mst = M_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      mst   <= M_IDLE;
      div   <= 16'h0;
      edges <= 5'h0;
      tx_sh <= `RST_BYTE;
      rx_sh <= `RST_BYTE;
      sck   <= 1'b1;
      msdo  <= 1'b0;
    end else begin
      mst   <= next_mst;
      div   <= next_div;
      edges <= next_edges;
      tx_sh <= next_tx_sh;
      rx_sh <= next_rx_sh;
      sck   <= next_sck;
      msdo  <= next_msdo;
    end
  end

  // pin synchronisers and link-event crossing
  always_ff @(posedge CLK) begin
    if (RESET) begin
      sdi_s1   <= 1'b0;
      sdi_s2   <= 1'b0;
      scs_s1   <= 1'b1;
      scs_s2   <= 1'b1;
      dn_s1    <= 1'b0;
      dn_s2    <= 1'b0;
      dn_s3    <= 1'b0;
      link_rst <= 1'b1;
    end else begin
      sdi_s1   <= SDI;
      sdi_s2   <= sdi_s1;
      scs_s1   <= SCS_N_IN;
      scs_s2   <= scs_s1;
      dn_s1    <= lk.done_tgl;
      dn_s2    <= dn_s1;
      dn_s3    <= dn_s2;
      link_rst <= 1'b0;
    end
  end

  // pad drive: master owns sck, and select when select_pin_enable is set, slave only data out
  assign pads_oe = enable & master;
  always_ff @(posedge CLK) begin
    if (RESET) begin
      SCK_OUT   <= 1'b1;
      SCK_OE    <= 1'b0;
      SCS_N_OUT <= 1'b1;
      SCS_N_OE  <= 1'b0;
      SDO_OE    <= 1'b0;
    end else begin
      SCK_OUT   <= next_sck;
      SCK_OE    <= pads_oe;
      // master asserts select around its frame
      SCS_N_OUT <= (next_mst != M_RUN);
      SCS_N_OE  <= pads_oe & select_pin_enable;
      SDO_OE    <= enable & (master | ~select_pin_enable | ~scs_s2);
    end
  end
  // slave bit must follow the link clock without system delay
  assign SDO_OUT = master ? msdo : lk.sdo_bit;

  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);

  no_start_off_a: assert property ($rose(mst) |-> $past(enable) && $past(master))
    else $error("master started while disabled");
  write_start_a: assert property ((wr_data && enable && master && !busy)
    |=> (mst == M_RUN) && (tx_sh == $past(PWDATA[7:0])))
    else $error("data write did not start transfer");
  trf_sticky_a: assert property ((transfer_complete_flag && !wr_fmt) |=> transfer_complete_flag)
    else $error("complete flag dropped without clear");
  trf_set_a: assert property ((m_done || s_done) |=> transfer_complete_flag)
    else $error("complete flag not set at end");
  slave_land_a: assert property ((s_done && !m_done) |=> data == $past(lk.rx_word))
    else $error("slave byte not stored");
  idle_level_a: assert property ((mst == M_IDLE) |=> (sck == !$past(pol)))
    else $error("sck idle level wrong");
  select_pin_enable_float_a: assert property ((!select_pin_enable) |=> !SCS_N_OE)
    else $error("select pin driven while disabled");
  always_sel_a: assert property ((enable && !master && !select_pin_enable) |-> !lk.sel_n)
    else $error("slave not selected with pin disabled");
  collision_a: assert property ((wr_data && busy && !m_done && !s_done)
    |=> write_collision_flag && data == $past(data))
    else $error("busy write not ignored");
  frame_len_a: assert property ($rose(mst) |-> (mst == M_RUN)[*8])
    else $error("master frame too short");
endmodule // spi_shift_engine
`default_nettype wire

// ### spi_far_end.sv
// Purpose: far-side spi peer, slave to the master shifter, master to the slave one
// Assumes: behavioural, steered by the bench through tasks
// Notes:   after its last capture the data line shows the inverse of its last bit; frame restores that bit at deselection
`timescale 1ns/1ps
`default_nettype none
module spi_far_end (
  input  wire logic clk,
  input  wire logic sck_out,
  input  wire logic sdo_out,
  output logic      link_sck,
  output logic      sdi,
  output logic      scs_n
);
  logic [7:0] tx;      // byte we send
  logic [7:0] rx;      // byte we received
  logic       cke;     // capture on leading edge
  logic       lsb;     // lsb first
  logic       armed;   // following the master clock
  logic       sdo_mid; // design data taken mid cycle
  int         e;       // clock edge count
  initial begin
    link_sck = 1'b1;
    sdi      = 1'b0;
    scs_n    = 1'b1;
    armed    = 1'b0;
  end
  // wire position of the k-th bit
  function automatic int pos(input int k);
    return lsb ? k : 7 - k;
  endfunction
  // setup value, taken away from the launching edge
  always @(negedge clk) sdo_mid = sdo_out;
  // slave role: capture, then show the next bit
  always @(sck_out) begin
    if (armed) begin
      e = e + 1;
      if ((e % 2 == 1) == cke) begin
        rx[pos((e - 1) / 2)] = sdo_mid;
        sdi = (e < 15) ? tx[pos((e + 1) / 2)] : ~sdi;
      end
      if (e == 16) armed = 1'b0;
    end
  end
  // get ready for one byte from the design's master
  task automatic arm(input logic [7:0] b, input logic c, input logic l);
    tx = b;
    cke = c;
    lsb = l;
    e = 0;
    sdi = tx[pos(0)];
    armed = 1'b1;
  endtask
  // park the link clock at its idle level
  task automatic idle(input logic pol);
    link_sck = !pol;
  endtask
  // master role: one byte at a 30 ns clock that stands still between frames
  task automatic frame(input logic [7:0] b, input logic c, input logic l, input logic sel);
    tx = b;
    cke = c;
    lsb = l;
    #7;
    scs_n = !sel; // select goes first, clocks after
    sdi = tx[pos(0)];
    #15;
    for (int i = 1; i <= 16; i++) begin
      if ((i % 2 == 1) == cke) begin
        rx[pos((i - 1) / 2)] = sdo_out;
        link_sck = ~link_sck;
        #2;
        sdi = (i < 15) ? tx[pos((i + 1) / 2)] : ~sdi;
        #13;
      end else begin
        link_sck = ~link_sck;
        #15;
      end
    end
    scs_n = 1'b1;
    sdi = ~sdi;
  endtask
endmodule // spi_far_end
`default_nettype wire

// ### spi_shift_engine_test.sv
// Purpose: self-checking bench of the spi shift engine
// Assumes: apb master here, far-side peer in spi_far_end
// Notes:   random bytes from a fixed seed
`include "spi_shift_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module spi_shift_engine_test;
  logic        clk, reset, psel, penable, pwrite; // system side
  logic [7:0]  paddr, tx, px, f;                   // address, bytes, format
  logic [31:0] pwdata, prdata, rd;                 // apb data
  logic        pready, pslverr, err;               // apb answer
  logic        sck_out, sck_oe, sdo_out, sdo_oe;   // design pins
  logic        scs_n_out, scs_n_oe, sck_pin, scs_pin;
  logic        far_sck, far_sdi, far_scs_n;        // peer drives
  logic        pol, cke, lsb, select_pin_enable;                // frame setup
  int          num_errors = 0;
  int          n_compared = 0;
  int          cyc = 0;
  // shared pins resolve from the enables
  assign sck_pin = sck_oe ? sck_out : far_sck;
  assign scs_pin = scs_n_oe ? scs_n_out : far_scs_n;
  always #5 clk = ~clk;
  spi_shift_engine dut (
    .CLK(clk), .RESET(reset), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .LINK_SCK(sck_pin), .SDI(far_sdi), .SCS_N_IN(scs_pin),
    .SCK_OUT(sck_out), .SCK_OE(sck_oe), .SDO_OUT(sdo_out), .SDO_OE(sdo_oe),
    .SCS_N_OUT(scs_n_out), .SCS_N_OE(scs_n_oe)
  );
  spi_far_end far (
    .clk(clk), .sck_out(sck_out), .sdo_out(sdo_out),
    .link_sck(far_sck), .sdi(far_sdi), .scs_n(far_scs_n)
  );
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      $display("CHECK FAILED at %0t: timeout", $time);
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] x, input string w);
    n_compared++;
    if (got !== x) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, w, got, x);
    end
  endtask
  // one apb transfer, held until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, err);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] x, input string w);
    apb(1'b0, a, 32'h0, rd, err);
    check(rd, x, w);
  endtask
  // poll until the complete flag shows
  task automatic wait_trf();
    for (int i = 0; i < 60; i++) begin
      apb(1'b0, `OFS_FORMAT, 32'h0, rd, err);
      if (rd[`FMT_TRF] === 1'b1) break;
    end
  endtask
  function automatic logic [7:0] fmt(input logic p, input logic c, input logic l,
                                     input logic s);
    return {2'b00, p, c, l, s, 2'b00};
  endfunction
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    void'($urandom(32'h85c49237));
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    // reset values, unmapped word, spare bits and flags
    rdchk(`OFS_CONTROL, 32'h0, "control reset");
    rdchk(`OFS_FORMAT, 32'h0, "format reset");
    rdchk(`OFS_DATA, 32'h0, "data reset");
    apb(1'b0, 8'h0c, 32'h0, rd, err);
    check(err, 1'b1, "unmapped error");
    wr(`OFS_FORMAT, 32'hff);
    rdchk(`OFS_FORMAT, 32'hfc, "format write");
    $display("test registers done");
    // master bit without enable: nothing may move
    wr(`OFS_CONTROL, 32'h2);
    wr(`OFS_DATA, 32'h5a);
    repeat (40) begin
      @(posedge clk);
      check({sck_oe, sdo_oe}, 2'b00, "disabled drive");
    end
    rdchk(`OFS_FORMAT, 32'hfc, "disabled flags");
    $display("test disabled done");
    // master: every mode and order, busy write collides
    for (int m = 0; m < 8; m++) begin
      {lsb, cke, pol} = m[2:0];
      select_pin_enable = m[0] ^ m[1];
      tx = 8'($urandom);
      px = 8'($urandom);
      f = fmt(pol, cke, !lsb, select_pin_enable);
      wr(`OFS_FORMAT, {24'h0, f});
      wr(`OFS_CONTROL, 32'h3);
      far.arm(px, cke, lsb);
      wr(`OFS_DATA, {24'h0, tx});
      wr(`OFS_DATA, {24'h0, ~tx});
      check(scs_n_oe, select_pin_enable, "select drive");
      check(sdo_oe, 1'b1, "master drive");
      if (select_pin_enable) check(scs_n_out, 1'b0, "select low");
      wait_trf();
      check(sck_out, !pol, "clock idle");
      check(rd[7:0], {f[7:2], 2'b11}, "master flags");
      rdchk(`OFS_DATA, px, "master rx");
      check(far.rx, tx, "master tx");
      wr(`OFS_FORMAT, {24'h0, f});
      rdchk(`OFS_FORMAT, f, "flags cleared");
    end
    $display("test master done");
    // slave: every mode, with and without the select pin
    for (int m = 0; m < 8; m++) begin
      {lsb, cke, pol} = m[2:0];
      select_pin_enable = m[1] ^ m[2];
      tx = 8'($urandom);
      px = 8'($urandom);
      f = fmt(pol, cke, !lsb, select_pin_enable);
      wr(`OFS_CONTROL, 32'h0);
      far.idle(pol);
      wr(`OFS_FORMAT, {24'h0, f});
      wr(`OFS_CONTROL, 32'h1);
      wr(`OFS_DATA, {24'h0, tx});
      check(sdo_oe, !select_pin_enable, "slave drive");
      if (select_pin_enable) begin
        far.frame(px, cke, lsb, 1'b0);
        repeat (8) @(posedge clk);
        rdchk(`OFS_FORMAT, f, "deselected clocks");
      end
      far.frame(px, cke, lsb, select_pin_enable);
      wait_trf();
      check(rd[7:0], {f[7:1], 1'b1}, "slave flags");
      rdchk(`OFS_DATA, px, "slave rx");
      check(far.rx, tx, "slave tx");
      wr(`OFS_FORMAT, {24'h0, f});
    end
    $display("test slave done");
    wrap_up();
  end
endmodule // spi_shift_engine_test
`default_nettype wire
